// File: srw_pkg.sv
// srw_pkg: constants for the supervisor reset and watchdog block
// assumes a 200 MHz system clock and an analog comparator outside
// How it works
// - reset pulses on power-up, supply loss, and watchdog expiry.
// - pulse lasts nominally 200 ms; polarity low or high by variant.
// - rising supply past trip level holds reset one pulse, then releases.
// - supply below trip level keeps reset asserted as long as it stays low.
// - constant activity input level beyond timeout, nominally 1.6 s, fires reset.
// - end of a watchdog reset restarts a fresh timeout interval.
// - input held steady gives reset every timeout plus pulse, about 1.8 s.
// - floating input is a third level; moves to or from it count.
package srw_pkg;
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned PULSE_MS = 200;
    localparam int unsigned TIMEOUT_MS = 1600;
    localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
    localparam int unsigned PULSE_CYC = PULSE_MS * CYC_PER_MS;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CYC_PER_MS;
    localparam int CNT_W = 32;
    // -----------------------------------------------------------------
    // activity input levels
    // -----------------------------------------------------------------
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [2:0] SYNC_RST = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h1;
endpackage : srw_pkg

// File: srw_sync3.sv
// srw_sync3: three-stage synchroniser with agreement filter
// assumes input is asynchronous to the clock
`timescale 1ns/100ps
module srw_sync3
    import srw_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic ASYNC_IN,
    output logic SYNC_OUT
);
    logic [2:0] sh_q;
    logic out_q;
    // -----------------------------------------------------------------
    // shift and agree
    // -----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sh_q <= SYNC_RST;
        end else begin
            sh_q <= {sh_q[1:0], ASYNC_IN};
        end
    end
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            out_q <= 1'b0;
        end else if (sh_q[1] == sh_q[2]) begin
            out_q <= sh_q[2];
        end
    end
    assign SYNC_OUT = out_q;
endmodule : srw_sync3

// File: srw_top.sv
// srw_top: reset pulse generator and watchdog of a supply supervisor
// assumes comparator flags for supply and activity input levels
`timescale 1ns/100ps
module srw_top
    import srw_pkg::*;
#(
    parameter logic [CNT_W-1:0] PULSE_DURATION = CNT_W'(PULSE_CYC),
    parameter logic [CNT_W-1:0] SERVICE_TIMEOUT = CNT_W'(TIMEOUT_CYC),
    parameter bit ACTIVE_HIGH = 1'b0
)
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic SUPPLY_LOW,
    input wire logic ACTIVITY_HI,
    input wire logic ACTIVITY_LO,
    output logic RESET_OUT,
    output logic RESET_ACTIVE,
    output logic WDOG_FIRED
);
    typedef enum logic [1:0] {ST_LOW, ST_PULSE, ST_RUN} srw_state_e;
    srw_state_e state_q;
    logic sup_low;
    logic act_hi;
    logic act_lo;
    logic [1:0] lvl_d;
    logic [1:0] lvl_q;
    logic activity;
    logic [CNT_W-1:0] pulse_cnt_q;
    logic [CNT_W-1:0] wd_cnt_q;
    logic wd_expire;
    logic pulse_done;
    logic rst_q;
    logic wd_fired_q;
    // -----------------------------------------------------------------
    // input synchronisers
    // -----------------------------------------------------------------
    srw_sync3 u_sup (
        .SYS_CLK(SYS_CLK),
        .RST(RST),
        .ASYNC_IN(SUPPLY_LOW),
        .SYNC_OUT(sup_low)
    );
    srw_sync3 u_hi (
        .SYS_CLK(SYS_CLK),
        .RST(RST),
        .ASYNC_IN(ACTIVITY_HI),
        .SYNC_OUT(act_hi)
    );
    srw_sync3 u_lo (
        .SYS_CLK(SYS_CLK),
        .RST(RST),
        .ASYNC_IN(ACTIVITY_LO),
        .SYNC_OUT(act_lo)
    );
    // -----------------------------------------------------------------
    // three-level activity detect
    // -----------------------------------------------------------------
    function automatic logic [1:0] lvl_of(input logic hi, input logic lo);
        if (hi) begin
            lvl_of = LVL_HIGH;
        end else if (lo) begin
            lvl_of = LVL_LOW;
        end else begin
            lvl_of = LVL_MID;
        end
    endfunction : lvl_of
    assign lvl_d = lvl_of(act_hi, act_lo);
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            lvl_q <= LVL_MID;
        end else begin
            lvl_q <= lvl_d;
        end
    end
    assign activity = (lvl_d != lvl_q);
    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    assign pulse_done = (pulse_cnt_q >= PULSE_DURATION - CNT_ONE);
    assign wd_expire = (wd_cnt_q >= SERVICE_TIMEOUT - CNT_ONE);
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_q <= ST_LOW;
        end else if (sup_low) begin
            state_q <= ST_LOW;
        end else begin
            unique case (state_q)
                ST_LOW: begin
                    state_q <= ST_PULSE;
                end
                ST_PULSE: begin
                    if (pulse_done) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (wd_expire && !activity) begin
                        state_q <= ST_PULSE;
                    end
                end
            endcase
        end
    end
    // -----------------------------------------------------------------
    // counters
    // -----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pulse_cnt_q <= CNT_ZERO;
        end else if (state_q != ST_PULSE || sup_low) begin
            pulse_cnt_q <= CNT_ZERO;
        end else begin
            pulse_cnt_q <= pulse_cnt_q + CNT_ONE;
        end
    end
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wd_cnt_q <= CNT_ZERO;
        end else if (state_q != ST_RUN || activity || wd_expire) begin
            wd_cnt_q <= CNT_ZERO;
        end else begin
            wd_cnt_q <= wd_cnt_q + CNT_ONE;
        end
    end
    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rst_q <= 1'b1;
        end else begin
            rst_q <= sup_low || (state_q != ST_RUN)
                || (state_q == ST_RUN && wd_expire && !activity);
        end
    end
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wd_fired_q <= 1'b0;
        end else begin
            wd_fired_q <= !sup_low && state_q == ST_RUN
                && wd_expire && !activity;
        end
    end
    assign RESET_OUT = ACTIVE_HIGH ? rst_q : !rst_q;
    assign RESET_ACTIVE = rst_q;
    assign WDOG_FIRED = wd_fired_q;
endmodule : srw_top

// File: srw_checker.sv
// srw_checker: reset pulse and watchdog timing checks
// assumes binding to srw_top
`timescale 1ns/100ps
module srw_checker
    import srw_pkg::*;
#(
    parameter logic [CNT_W-1:0] PULSE_DURATION = 32'h14,
    parameter logic [CNT_W-1:0] SERVICE_TIMEOUT = 32'h32,
    parameter bit ACTIVE_HIGH = 1'b0
)
(
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic SUPPLY_LOW,
    input wire logic ACTIVITY_HI,
    input wire logic ACTIVITY_LO,
    input wire logic RESET_OUT,
    input wire logic RESET_ACTIVE,
    input wire logic WDOG_FIRED
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    logic [CNT_W-1:0] act_q, quiet_q;
    logic [1:0] lvl_q;
    // reset length and quiet time counters
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            act_q <= '0;
            quiet_q <= '0;
            lvl_q <= '0;
        end else begin
            lvl_q <= {ACTIVITY_HI, ACTIVITY_LO};
            act_q <= RESET_ACTIVE ? act_q + 1 : '0;
            quiet_q <= (RESET_ACTIVE || lvl_q != {ACTIVITY_HI, ACTIVITY_LO})
                ? '0 : quiet_q + 1;
        end
    end
    property p_pol; RESET_OUT == (ACTIVE_HIGH ? RESET_ACTIVE : !RESET_ACTIVE);
    endproperty
    a_pol: assert property (p_pol) else $error("polarity");
    property p_width; $fell(RESET_ACTIVE) |-> act_q >= PULSE_DURATION - 1;
    endproperty
    a_width: assert property (p_width) else $error("short pulse");
    property p_low; SUPPLY_LOW [*8] |-> RESET_ACTIVE; endproperty
    a_low: assert property (p_low) else $error("no reset");
    property p_rel; $fell(RESET_ACTIVE) |-> !$past(SUPPLY_LOW, 8); endproperty
    a_rel: assert property (p_rel) else $error("early release");
    property p_one; WDOG_FIRED |=> !WDOG_FIRED; endproperty
    a_one: assert property (p_one) else $error("long fire");
    property p_hold; WDOG_FIRED |-> RESET_ACTIVE ##1 RESET_ACTIVE [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("fire w/o reset");
    property p_wmin; WDOG_FIRED |-> quiet_q >= SERVICE_TIMEOUT - 6; endproperty
    a_wmin: assert property (p_wmin) else $error("early fire");
    property p_wmax; quiet_q <= SERVICE_TIMEOUT + 8; endproperty
    a_wmax: assert property (p_wmax) else $error("late fire");
endmodule : srw_checker

// File: srw_host_model.sv
// srw_host_model: processor side driving the activity input
// assumes the bench clock; level flags as the comparators would give
`timescale 1ns/100ps
module srw_host_model (
    input wire logic clk,
    input wire logic [1:0] mode,
    output logic act_hi,
    output logic act_lo
);
    logic [3:0] t_q = 4'h0;
    logic ph_q = 1'b0;
    always_ff @(posedge clk) begin
        t_q <= t_q + 4'h1;
        if (t_q == 4'hf) ph_q <= !ph_q;
    end
    // 0 toggles, 1 floats and drives high, 2 holds high
    assign act_hi = mode == 2'h2 || ph_q;
    assign act_lo = mode == 2'h0 && !ph_q;
endmodule : srw_host_model

// File: srw_tb.sv
// testbench: supply, activity and watchdog scenarios
`timescale 1ns/100ps
module testbench
    import srw_pkg::*;
;
    localparam int PI = 32'h14;
    localparam int TI = 32'h32;
    logic sys_clk = 0, rst = 1, supply_low = 0;
    logic [1:0] mode = 2'h0;
    logic act_hi, act_lo, reset_active, wdog_fired, reset_out;
    logic [15:0] lfsr_q = 16'h0102;
    int bad_count = 0, comparisons = 0, cyc = 0;
    initial forever #2.5 sys_clk = ~sys_clk;
    srw_top #(.PULSE_DURATION(CNT_W'(PI)), .SERVICE_TIMEOUT(CNT_W'(TI))) u_dut (
        .SYS_CLK(sys_clk), .RST(rst), .SUPPLY_LOW(supply_low),
        .ACTIVITY_HI(act_hi), .ACTIVITY_LO(act_lo), .RESET_OUT(reset_out),
        .RESET_ACTIVE(reset_active), .WDOG_FIRED(wdog_fired));
    srw_host_model u_host (.clk(sys_clk), .mode(mode), .act_hi(act_hi),
        .act_lo(act_lo));
    function logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    function logic in_win(input int n, input int lo, input int hi);
        return n >= lo && n <= hi;
    endfunction : in_win
    task chk(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    task wait_on(input logic lvl, output int n);
        n = 0;
        do begin @(negedge sys_clk); n++; end
        while ((lvl ? wdog_fired : reset_active) !== lvl && n < 500);
    endtask : wait_on
    task quiet_run(input logic [1:0] m);
        int f;
        f = 0;
        @(posedge sys_clk) mode <= m;
        repeat (300) @(negedge sys_clk) if (wdog_fired === 1'b1) f++;
        $display("test mode %0d done", m);
        chk(f == 0, 1'b1);
    endtask : quiet_run
    always @(posedge sys_clk) if (++cyc == 20000) begin bad_count++; stop_test(); end
    initial begin
        int n;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        wait_on(1'b0, n);
        chk(in_win(n, PI, PI + 10), 1'b1);
        chk(reset_out, 1'b1);
        $display("test power-up done");
        quiet_run(2'h0);
        quiet_run(2'h1);
        @(posedge sys_clk) mode <= 2'h2;
        wait_on(1'b1, n);
        chk(n < 500, 1'b1);
        wait_on(1'b1, n);
        $display("test held input done");
        chk(in_win(n, TI + PI - 2, TI + PI + 10), 1'b1);
        repeat (3) begin
            lfsr_q = lfsr(lfsr_q);
            @(posedge sys_clk) supply_low <= 1'b1;
            repeat (8 + lfsr_q[5:0]) @(posedge sys_clk);
            @(negedge sys_clk) chk(reset_active, 1'b1);
            chk(reset_out, 1'b0);
            @(posedge sys_clk) supply_low <= 1'b0;
            wait_on(1'b0, n);
            chk(in_win(n, PI, PI + 10), 1'b1);
        end
        $display("test supply done");
        stop_test();
    end
endmodule : testbench
bind srw_top srw_checker #(.PULSE_DURATION(PULSE_DURATION),
    .SERVICE_TIMEOUT(SERVICE_TIMEOUT), .ACTIVE_HIGH(ACTIVE_HIGH)) u_chk (
    .SYS_CLK(SYS_CLK), .RST(RST), .SUPPLY_LOW(SUPPLY_LOW),
    .ACTIVITY_HI(ACTIVITY_HI), .ACTIVITY_LO(ACTIVITY_LO), .RESET_OUT(RESET_OUT),
    .RESET_ACTIVE(RESET_ACTIVE), .WDOG_FIRED(WDOG_FIRED));
